// [inc/fsir_regs.svh]
// Notes on behaviour
// RULE1: Fill count register shows FIFO byte count in bits 6..0, bit 7 zero.
// RULE2: Each FIFO write adds one to the count, each FIFO read subtracts one.
// RULE3: Status bit 7 shows the timer is running.
// RULE4: Status bit 6 is one when memory programming has finished.
// RULE5: Status bit 5 is one when the checksum calculation has finished.
// RULE6: Status bits 2..0 give valid bits of last received byte, zero means all.
// RULE7: Enable write sets marked bits when bit 7 is one, else clears them.
// RULE8: Enable bits 5..0 gate timer, transmit, receive, idle, high, low requests.
// RULE9: Request write sets marked flags when bit 7 is one, else clears them.
// RULE10: Timer request rises when the timer count reaches zero.
// RULE11: Transmit request rises when send, program or checksum data is finished.
// RULE12: Receive request rises when the receiver ends a reception.
// RULE13: Idle request rises on correct command end or unknown command start.
// RULE14: Host start of the idle command does not raise the idle request.
// RULE15: Alert requests latch on alert status and hold until cleared by write.
// RULE16: Pending summary bit is one when any enabled request is set.
// RULE17: High alert is true when free space is at most the threshold.
// RULE18: Low alert is true when fill count is at most the threshold.
// RULE19: Interrupt pin is high when any enabled request flag is set.
`ifndef FSIR_REGS_SVH
`define FSIR_REGS_SVH
`define FSIR_ADDR_FILL      6'h04
`define FSIR_ADDR_AUX       6'h05
`define FSIR_ADDR_IEN       6'h06
`define FSIR_ADDR_IRQ       6'h07
`define FSIR_RST_FILL       8'h00
`define FSIR_RST_AUX        8'h60
`define FSIR_RST_IEN        6'h00
`define FSIR_RST_IRQ        6'h00
`define FSIR_BIT_POLARITY   7
`define FSIR_BIT_TIMER_RUN  7
`define FSIR_BIT_NVM_DONE   6
`define FSIR_BIT_CRC_DONE   5
`define FSIR_FIFO_DEPTH     7'h40
`endif

// [inc/fsir_pkg.sv]
`default_nettype none
package fsir_pkg;
  // Request flags, bit order as in the request and enable registers
  typedef struct packed {
    logic timer;
    logic transmit;
    logic receive;
    logic idle;
    logic high_alert;
    logic low_alert;
  } irq_vec_type;

  // Register access from the host interface
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [5:0] addr;
    logic [7:0] wdata;
  } reg_req_type;

  // Device status inputs from the engines
  typedef struct packed {
    logic       timer_active_flag;
    logic       nvm_write_done;
    logic       checksum_done;
    logic [2:0] last_byte_valid_bits;
  } aux_in_type;

  // Flag update kind on a masked write
  typedef enum logic [1:0] {
    UPD_NONE  = 2'b00,
    UPD_SET   = 2'b01,
    UPD_CLEAR = 2'b11
  } upd_type;
endpackage : fsir_pkg
`default_nettype wire

// [rtl/fsir_fill_counter.sv]
`timescale 1ns/1ns
`default_nettype none
`include "fsir_regs.svh"
module fsir_fill_counter #(
  parameter int CW = 7
) (
  input  wire logic          ref_clk_i,
  input  wire logic          rst_n_i,
  input  wire logic          flush_i,
  input  wire logic          push_i,
  input  wire logic          pop_i,
  output logic [CW-1:0]      count_o
);
  if (CW < 7) begin : g_cw_check
    $error("fill counter too narrow");
  end

  logic [CW-1:0] count_d;
  logic [CW-1:0] count_q;

  always_comb begin
    count_d = count_q;
    if (flush_i) begin
      count_d = '0;
    end else if (push_i && !pop_i) begin
      count_d = count_q + CW'(1); // [RULE2]
    end else if (pop_i && !push_i) begin
      count_d = count_q - CW'(1); // [RULE2]
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      count_q <= '0;
    end else begin
      count_q <= count_d;
    end
  end

  assign count_o = count_q;

  a_count_push: assert property ( // [RULE2]
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (push_i && !pop_i && !flush_i) |=> count_q == $past(count_q) + CW'(1))
    else $error("fill count did not increment");
  a_count_pop: assert property ( // [RULE2]
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (pop_i && !push_i && !flush_i) |=> count_q == $past(count_q) - CW'(1))
    else $error("fill count did not decrement");
endmodule : fsir_fill_counter
`default_nettype wire

// [rtl/fsir_regs_top.sv]
`timescale 1ns/1ns
`default_nettype none
`include "fsir_regs.svh"
module fsir_regs_top (
  input  wire logic                 ref_clk_i,
  input  wire logic                 rst_n_i,
  input  wire fsir_pkg::reg_req_type reg_req_i,
  output logic [7:0]                reg_rdata_o,
  input  wire logic                 fifo_push_i,
  input  wire logic                 fifo_pop_i,
  input  wire logic                 fifo_flush_i,
  input  wire logic [6:0]           fifo_threshold_i,
  input  wire fsir_pkg::aux_in_type aux_i,
  input  wire logic                 timer_zero_i,
  input  wire logic                 tx_done_i,
  input  wire logic                 rx_end_i,
  input  wire logic                 cmd_end_ok_i,
  input  wire logic                 cmd_unknown_i,
  input  wire logic                 host_idle_start_i,
  output logic                      fifo_near_full_o,
  output logic                      fifo_near_empty_o,
  output logic                      irq_pending_o,
  output logic                      irq_o
);
  import fsir_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // Constant sanity
  if (7 < $clog2(`FSIR_FIFO_DEPTH + 1)) begin : g_depth_check
    $error("fill count cannot reach the fifo depth");
  end

  //////////////////////////////////////////////////////////////////////////
  // Fill count
  logic [6:0] fill_count;

  fsir_fill_counter #(
    .CW(7)
  ) u_fill (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .flush_i   (fifo_flush_i),
    .push_i    (fifo_push_i),
    .pop_i     (fifo_pop_i),
    .count_o   (fill_count)
  );

  //////////////////////////////////////////////////////////////////////////
  // Alert levels
  logic       near_full;
  logic       near_empty;
  logic [6:0] free_space;

  always_comb begin
    free_space = `FSIR_FIFO_DEPTH - fill_count;
    near_full  = free_space <= fifo_threshold_i; // [RULE17]
    near_empty = fill_count <= fifo_threshold_i; // [RULE18]
  end

  //////////////////////////////////////////////////////////////////////////
  // Masked write helper
  function automatic irq_vec_type apply_write(irq_vec_type cur,
                                              logic [7:0] wd);
    irq_vec_type marked;
    marked = irq_vec_type'(wd[5:0]);
    if (wd[`FSIR_BIT_POLARITY]) begin
      apply_write = cur | marked;
    end else begin
      apply_write = cur & ~marked;
    end
  endfunction : apply_write

  // Any request that is both set and enabled
  function automatic logic any_enabled(irq_vec_type flags,
                                       irq_vec_type mask);
    any_enabled = |(flags & mask);
  endfunction : any_enabled

  //////////////////////////////////////////////////////////////////////////
  // Enable mask and request flags
  irq_vec_type ien_d;
  irq_vec_type ien_q;
  irq_vec_type irq_d;
  irq_vec_type irq_q;
  irq_vec_type events;
  logic        ien_wr;
  logic        irq_wr;

  always_comb begin
    ien_wr = reg_req_i.wr && reg_req_i.addr == `FSIR_ADDR_IEN;
    irq_wr = reg_req_i.wr && reg_req_i.addr == `FSIR_ADDR_IRQ;
    events.timer      = timer_zero_i; // [RULE10]
    events.transmit   = tx_done_i; // [RULE11]
    events.receive    = rx_end_i; // [RULE12]
    events.idle       = (cmd_end_ok_i && !host_idle_start_i)
                        || cmd_unknown_i; // [RULE13] [RULE14]
    events.high_alert = near_full; // [RULE15]
    events.low_alert  = near_empty; // [RULE15]
    ien_d = ien_q;
    if (ien_wr) begin
      ien_d = apply_write(ien_q, reg_req_i.wdata); // [RULE7]
    end
    irq_d = irq_q;
    if (irq_wr) begin
      irq_d = apply_write(irq_q, reg_req_i.wdata); // [RULE9]
    end
    irq_d = irq_d | events; // [RULE15]
  end

  //////////////////////////////////////////////////////////////////////////
  // Outputs and read data
  logic [7:0] rdata_d;
  logic [7:0] rdata_q;
  logic       pend_d;
  logic       pend_q;
  logic       nf_q;
  logic       ne_q;

  always_comb begin
    pend_d = any_enabled(irq_d, ien_d); // [RULE16] [RULE8]
    rdata_d = rdata_q;
    if (reg_req_i.rd) begin
      unique case (reg_req_i.addr)
        `FSIR_ADDR_FILL: rdata_d = {1'b0, fill_count}; // [RULE1]
        `FSIR_ADDR_AUX:  rdata_d = {aux_i.timer_active_flag, // [RULE3]
                                    aux_i.nvm_write_done, // [RULE4]
                                    aux_i.checksum_done, // [RULE5]
                                    2'b00,
                                    aux_i.last_byte_valid_bits}; // [RULE6]
        `FSIR_ADDR_IEN:  rdata_d = {2'b00, ien_q};
        `FSIR_ADDR_IRQ:  rdata_d = {2'b00, irq_q};
        default:         rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      ien_q   <= irq_vec_type'(`FSIR_RST_IEN);
      irq_q   <= irq_vec_type'(`FSIR_RST_IRQ);
      rdata_q <= 8'h00;
      pend_q  <= 1'b0;
      nf_q    <= 1'b0;
      ne_q    <= 1'b0;
    end else begin
      ien_q   <= ien_d;
      irq_q   <= irq_d;
      rdata_q <= rdata_d;
      pend_q  <= pend_d;
      nf_q    <= near_full;
      ne_q    <= near_empty;
    end
  end

  assign reg_rdata_o       = rdata_q;
  assign irq_pending_o     = pend_q;
  assign irq_o             = pend_q; // [RULE19]
  assign fifo_near_full_o  = nf_q;
  assign fifo_near_empty_o = ne_q;

  //////////////////////////////////////////////////////////////////////////
  // Checks
  a_ien_set: assert property ( // [RULE7]
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    ien_wr && reg_req_i.wdata[7]
    |=> (ien_q & $past(reg_req_i.wdata[5:0])) == $past(reg_req_i.wdata[5:0]))
    else $error("enable set failed");

  a_ien_clear: assert property ( // [RULE7]
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    ien_wr && !reg_req_i.wdata[7]
    |=> (ien_q & $past(reg_req_i.wdata[5:0])) == 6'h00)
    else $error("enable clear failed");

  a_ien_keep: assert property ( // [RULE7]
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    ien_wr
    |=> (ien_q & ~$past(reg_req_i.wdata[5:0]))
        == ($past(ien_q) & ~$past(reg_req_i.wdata[5:0])))
    else $error("unmarked enable bit changed");

  a_ien_hold: assert property ( // [RULE7]
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    !ien_wr
    |=> ien_q == $past(ien_q))
    else $error("enable changed without write");

  a_irq_set: assert property ( // [RULE9]
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    irq_wr && reg_req_i.wdata[7]
    |=> (irq_q & $past(reg_req_i.wdata[5:0])) == $past(reg_req_i.wdata[5:0]))
    else $error("request set failed");

  a_irq_clear: assert property ( // [RULE9]
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    irq_wr && !reg_req_i.wdata[7] && events == '0
    |=> (irq_q & $past(reg_req_i.wdata[5:0])) == 6'h00)
    else $error("request clear failed");

  a_flag_rise: assert property ( // [RULE9]
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    !irq_wr && events == '0
    |=> (irq_q & ~$past(irq_q)) == 6'h00)
    else $error("request rose without cause");

  a_flag_hold: assert property ( // [RULE15]
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    !irq_wr
    |=> ($past(irq_q) & ~irq_q) == 6'h00)
    else $error("request dropped without write");

  a_timer_req: assert property ( // [RULE10]
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    timer_zero_i
    |=> irq_q.timer)
    else $error("timer request missing");

  a_tx_req: assert property ( // [RULE11]
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    tx_done_i
    |=> irq_q.transmit)
    else $error("transmit request missing");

  a_rx_req: assert property ( // [RULE12]
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    rx_end_i
    |=> irq_q.receive)
    else $error("receive request missing");

  a_idle_req: assert property ( // [RULE13]
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    cmd_unknown_i
    |=> irq_q.idle)
    else $error("idle request missing");

  a_idle_end: assert property ( // [RULE13]
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    cmd_end_ok_i && !host_idle_start_i
    |=> irq_q.idle)
    else $error("idle request missing at command end");

  a_idle_host: assert property ( // [RULE14]
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    !irq_q.idle && host_idle_start_i && !cmd_unknown_i && !irq_wr
    |=> !irq_q.idle)
    else $error("host idle start raised request");

  a_alert_latch: assert property ( // [RULE15]
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    near_empty
    |=> irq_q.low_alert)
    else $error("low alert not latched");

  a_high_latch: assert property ( // [RULE15]
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    near_full
    |=> irq_q.high_alert)
    else $error("high alert not latched");

  a_pend_flags: assert property ( // [RULE16]
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    1'b1
    |-> irq_pending_o == any_enabled(irq_q, ien_q))
    else $error("pending bit disagrees with flags");

  a_pin_follow: assert property ( // [RULE19]
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    1'b1
    |-> irq_o == any_enabled(irq_q, ien_q))
    else $error("pin disagrees with flags");

  a_high_alert: assert property ( // [RULE17]
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    fill_count >= 7'h3C && fifo_threshold_i == 7'h04
    |=> fifo_near_full_o)
    else $error("high alert wrong");

  a_high_level: assert property ( // [RULE17]
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    1'b1
    |=> fifo_near_full_o
        == (`FSIR_FIFO_DEPTH - $past(fill_count) <= $past(fifo_threshold_i)))
    else $error("high alert level wrong");

  a_low_level: assert property ( // [RULE18]
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    1'b1
    |=> fifo_near_empty_o
        == ($past(fill_count) <= $past(fifo_threshold_i)))
    else $error("low alert level wrong");

  a_read_fill: assert property ( // [RULE1]
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    reg_req_i.rd && reg_req_i.addr == `FSIR_ADDR_FILL
    |=> reg_rdata_o == {1'b0, $past(fill_count)})
    else $error("fill count read wrong");

  a_read_aux: assert property ( // [RULE3] [RULE4] [RULE5] [RULE6]
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    reg_req_i.rd && reg_req_i.addr == `FSIR_ADDR_AUX
    |=> {reg_rdata_o[7:5], reg_rdata_o[2:0]} == $past(aux_i)
        && reg_rdata_o[4:3] == 2'b00)
    else $error("status read wrong");
endmodule : fsir_regs_top
`default_nettype wire

// [tb/fsir_host_model.sv]
`timescale 1ns/1ns
`default_nettype none
module fsir_host_model (
  input  wire logic                  ref_clk_i,
  output var  fsir_pkg::reg_req_type reg_req_o,
  input  wire logic [7:0]            reg_rdata_i
);
  import fsir_pkg::*;
  initial reg_req_o = '0;
  // Bit 7 of wdata picks set or clear of the marked bits
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(negedge ref_clk_i);
    reg_req_o = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge ref_clk_i);
    reg_req_o = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask : wr
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(negedge ref_clk_i);
    reg_req_o = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h5A};
    @(negedge ref_clk_i);
    reg_req_o = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hA5};
    d = reg_rdata_i;
  endtask : rd
endmodule : fsir_host_model
`default_nettype wire

// [tb/tb_fsir_regs_top.sv]
`timescale 1ns/1ns
`default_nettype none
module tb_fsir_regs_top;
  import fsir_pkg::*;
  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        push = 1'b0, pop = 1'b0, flush = 1'b0;
  logic [6:0]  thr = 7'h04;
  aux_in_type  aux = '{1'b0, 1'b1, 1'b1, 3'h0};
  logic [5:0]  ev_v = 6'h00;
  reg_req_type req;
  logic [7:0]  rdata, v;
  logic        nfull, nempty, pend, irq;
  int          failures = 0, samples_checked = 0;
  always #4 ref_clk = ~ref_clk;
  fsir_host_model u_host (.ref_clk_i(ref_clk), .reg_req_o(req),
                          .reg_rdata_i(rdata));
  fsir_regs_top DUT (.ref_clk_i(ref_clk), .rst_n_i(rst_n), .reg_req_i(req),
    .reg_rdata_o(rdata), .fifo_push_i(push), .fifo_pop_i(pop),
    .fifo_flush_i(flush), .fifo_threshold_i(thr), .aux_i(aux),
    .timer_zero_i(ev_v[5]), .tx_done_i(ev_v[4]), .rx_end_i(ev_v[3]),
    .cmd_end_ok_i(ev_v[2]), .cmd_unknown_i(ev_v[1]),
    .host_idle_start_i(ev_v[0]), .fifo_near_full_o(nfull),
    .fifo_near_empty_o(nempty), .irq_pending_o(pend), .irq_o(irq));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic rchk(input logic [5:0] a, input logic [7:0] exp);
    u_host.rd(a, v);
    check(v, exp);
  endtask : rchk
  task automatic fifo(input int np, input int npo);
    repeat (np) begin @(negedge ref_clk); push = 1'b1; end
    @(negedge ref_clk); push = 1'b0;
    repeat (npo) begin @(negedge ref_clk); pop = 1'b1; end
    @(negedge ref_clk); pop = 1'b0;
  endtask : fifo
  task automatic ev(input logic [5:0] e);
    @(negedge ref_clk); ev_v = e;
    @(negedge ref_clk); ev_v = 6'h00;
  endtask : ev
  task automatic t_reset;
    rchk(6'h04, 8'h00);
    rchk(6'h05, 8'h60);
    rchk(6'h06, 8'h00);
    rchk(6'h07, 8'h01);
    rchk(6'h3F, 8'h00);
    $display("test reset done");
  endtask : t_reset
  task automatic t_regs;
    aux = '{1'b1, 1'b0, 1'b1, 3'h5};
    rchk(6'h05, 8'hA5);
    fifo(10, 3);
    rchk(6'h04, 8'h07);
    u_host.wr(6'h04, 8'h33);
    rchk(6'h04, 8'h07);
    u_host.wr(6'h06, 8'hBF);
    rchk(6'h06, 8'h3F);
    u_host.wr(6'h06, 8'h2A);
    rchk(6'h06, 8'h15);
    u_host.wr(6'h06, 8'h15);
    $display("test registers done");
  endtask : t_regs
  task automatic t_events;
    logic [5:0] ein [6] = '{6'h20, 6'h10, 6'h08, 6'h04, 6'h02, 6'h05};
    logic [7:0] eq [6] = '{8'h20, 8'h10, 8'h08, 8'h04, 8'h04, 8'h00};
    u_host.wr(6'h07, 8'h3F);
    rchk(6'h07, 8'h00);
    for (int i = 0; i < 6; i++) begin
      ev(ein[i]);
      check({6'h00, irq, pend}, 8'h00);
      rchk(6'h07, eq[i]);
      u_host.wr(6'h07, 8'h3F);
    end
    u_host.wr(6'h06, 8'h84);
    ev(6'h04);
    check({6'h00, irq, pend}, 8'h03);
    u_host.wr(6'h07, 8'h04);
    check({6'h00, irq, pend}, 8'h00);
    u_host.wr(6'h07, 8'hA0);
    rchk(6'h07, 8'h20);
    check({7'h00, irq}, 8'h00);
    u_host.wr(6'h07, 8'h20);
    $display("test events done");
  endtask : t_events
  task automatic t_alert;
    fifo(53, 0);
    check({6'h00, nfull, nempty}, 8'h02);
    fifo(0, 1);
    @(negedge ref_clk);
    check({6'h00, nfull, nempty}, 8'h00);
    fifo(0, 54);
    @(negedge ref_clk);
    check({6'h00, nfull, nempty}, 8'h00);
    fifo(0, 1);
    @(negedge ref_clk);
    check({6'h00, nfull, nempty}, 8'h01);
    rchk(6'h07, 8'h03);
    @(negedge ref_clk); flush = 1'b1;
    @(negedge ref_clk); flush = 1'b0;
    rchk(6'h04, 8'h00);
    $display("test alerts done");
  endtask : t_alert
  task automatic end_of_test;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_of_test
  initial begin
    repeat (3) @(negedge ref_clk);
    rst_n = 1'b1;
    t_reset();
    t_regs();
    t_events();
    t_alert();
    end_of_test();
  end
  initial begin
    #100000;
    failures++;
    end_of_test();
  end
endmodule : tb_fsir_regs_top
`default_nettype wire
